// [inc/cs_reset_pkg.sv]
// Constants and carriers for the chip-select reset configuration block.
// Assumes a single system clock domain and an active-low system reset.
package cs_reset_pkg;

  // Number of general chip selects.
  localparam int unsigned NUM_CS = 11;

  // Block size encodings (3 bits).
  localparam logic [2:0] BLK_2K = 3'h0;
  localparam logic [2:0] BLK_1M = 3'h7;

  // Byte-lane encodings.
  localparam logic [1:0] BYTE_OFF  = 2'h0;
  localparam logic [1:0] BYTE_LOW  = 2'h1;
  localparam logic [1:0] BYTE_UP   = 2'h2;
  localparam logic [1:0] BYTE_BOTH = 2'h3;

  // Read/write encodings.
  localparam logic [1:0] RW_RSVD = 2'h0;
  localparam logic [1:0] RW_RD   = 2'h1;
  localparam logic [1:0] RW_WR   = 2'h2;
  localparam logic [1:0] RW_BOTH = 2'h3;

  // Space encodings.
  localparam logic [1:0] SPC_CPU  = 2'h0;
  localparam logic [1:0] SPC_USER = 2'h1;
  localparam logic [1:0] SPC_SUP  = 2'h2;
  localparam logic [1:0] SPC_SU   = 2'h3;

  // Wait-state encodings.
  localparam logic [3:0] WAIT_0  = 4'h0;
  localparam logic [3:0] WAIT_13 = 4'hD;
  localparam logic [3:0] WAIT_EXT = 4'hF;

  // Base address reset value (address bits 23:11).
  localparam logic [12:0] BASE_RST = 13'h0000;

  // First fetch address after reset.
  localparam logic [23:0] VEC_ADDR = 24'h00_0000;

  // Base register image.
  typedef struct packed {
    logic [12:0] baseAddr;
    logic [2:0]  blkSize;
  } base_reg_t;

  // Option register image.
  typedef struct packed {
    logic       syncMode;
    logic [1:0] byteLane;
    logic [1:0] readWrite;
    logic       strobeDs;
    logic [3:0] sizeAck;
    logic [1:0] space;
    logic [2:0] irqLevelMatch;
    logic       autoVectorReq;
  } option_reg_t;

  // One bus access as seen by the compare logic.
  typedef struct packed {
    logic [23:0] addr;
    logic [2:0]  funcCode;
    logic        read;
    logic [1:0]  lanes;
    logic        addrStrobe;
    logic        dataStrobe;
  } bus_access_t;

  localparam base_reg_t GEN_BASE_RST = '{BASE_RST, BLK_2K};
  localparam base_reg_t BOOT_BASE_RST = '{BASE_RST, BLK_1M};
  localparam option_reg_t GEN_OPT_RST =
    '{1'b0, BYTE_OFF, RW_RSVD, 1'b0, WAIT_0, SPC_CPU, 3'h0, 1'b0};
  localparam option_reg_t BOOT_OPT_RST =
    '{1'b0, BYTE_BOTH, RW_BOTH, 1'b0, WAIT_13, SPC_SU, 3'h0, 1'b0};

endpackage

// [rtl/chip_select_reset_config.sv]
// Chip-select configuration with reset-time strapping and output decode.
// Assumes the data bus straps are pins and software loads via ports.
`timescale 1ns/1ps
module chip_select_reset_config
  import cs_reset_pkg::*;
#(
  parameter int unsigned NUM_SEL = NUM_CS
)
(
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  input  wire logic [7:0]           dataStrap,
  input  wire logic                 cfgWrite,
  input  wire logic [3:0]           cfgIndex,
  input  wire logic                 cfgIsBase,
  input  wire base_reg_t            cfgBase,
  input  wire option_reg_t          cfgOpt,
  input  wire logic [1:0]           cfgPinFunc,
  input  wire bus_access_t          busAcc,
  output logic [NUM_SEL-1:0]        selectOut_n,
  output logic                      bootSelect_n,
  output logic [2*NUM_SEL-1:0]      pinFunc,
  output logic [1:0]                bootPinFunc,
  output option_reg_t               bootOptView,
  output base_reg_t                 bootBaseView,
  output logic [23:0]               firstFetchAddr
);

  ////////////////////////////////////////////////////////////////////////
  // Index decode shared by the register and pin-field writes.

  // True when a write index names one of the general selects.
  function automatic logic is_gen_index(input logic [3:0] idx);
    return idx < 4'(NUM_SEL);
  endfunction

  // True when a write index names the boot select, one past the last.
  function automatic logic is_boot_index(input logic [3:0] idx);
    return idx == 4'(NUM_SEL);
  endfunction

  // Data line that straps select n. There are more selects than strap
  // lines, so lines 1..7 are reused in turn and line 0 stays for boot.
  function automatic int strap_line(input int n);
    return 1 + (n % 7);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Strap synchronisers.
  logic [7:0] strapMeta_ff;
  logic [7:0] strapSync_ff;

  // Two flops before any logic sees the external data lines.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      strapMeta_ff <= 8'hff;
      strapSync_ff <= 8'hff;
    end else begin
      strapMeta_ff <= dataStrap;
      strapSync_ff <= strapMeta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin-function fields.
  logic [2*NUM_SEL-1:0] pinFunc_ff;
  logic [1:0]           bootPinFunc_ff;
  logic [2:0]           strapHold_ff;

  // Capture window: the synchroniser needs two edges after release,
  // so the latch stays open for three cycles, then holds.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      strapHold_ff <= 3'h0;
    end else if (strapHold_ff != 3'h7) begin
      strapHold_ff <= {strapHold_ff[1:0], 1'b1};
    end
  end

  // General pin-function fields.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_SEL; i++) begin
        pinFunc_ff[2*i]   <= 1'b1;
        pinFunc_ff[2*i+1] <= 1'b1;
      end
    end else if (!strapHold_ff[2]) begin
      for (int i = 0; i < NUM_SEL; i++) begin
        pinFunc_ff[2*i]   <= 1'b1;
        pinFunc_ff[2*i+1] <= strapSync_ff[strap_line(i)];
      end
    end else if (cfgWrite && !cfgIsBase && is_gen_index(cfgIndex)) begin
      pinFunc_ff[2*cfgIndex +: 2] <= cfgPinFunc;
    end
  end

  // Boot pin-function field.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bootPinFunc_ff <= 2'h3;
    end else if (!strapHold_ff[2]) begin
      bootPinFunc_ff <= {1'b1, strapSync_ff[0]};
    end else if (cfgWrite && !cfgIsBase && is_boot_index(cfgIndex)) begin
      bootPinFunc_ff <= cfgPinFunc;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Base and option registers.
  base_reg_t   baseReg_ff [NUM_SEL];
  option_reg_t optReg_ff  [NUM_SEL];
  base_reg_t   bootBase_ff;
  option_reg_t bootOpt_ff;

  // General registers; software writes pick the pair by index.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_SEL; i++) begin
        baseReg_ff[i] <= GEN_BASE_RST;
        optReg_ff[i]  <= GEN_OPT_RST;
      end
    end else if (cfgWrite && is_gen_index(cfgIndex)) begin
      if (cfgIsBase) begin
        baseReg_ff[cfgIndex] <= cfgBase;
      end else begin
        optReg_ff[cfgIndex] <= cfgOpt;
      end
    end
  end

  // Boot registers at index NUM_SEL.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      bootBase_ff <= BOOT_BASE_RST;
      bootOpt_ff  <= BOOT_OPT_RST;
    end else if (cfgWrite && is_boot_index(cfgIndex)) begin
      if (cfgIsBase) begin
        bootBase_ff <= cfgBase;
      end else begin
        bootOpt_ff <= cfgOpt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Select decode.
  logic [NUM_SEL-1:0] genHit;
  logic               bootHit;

  // A pin drives its select only when its field picks a select role.
  for (genvar g = 0; g < NUM_SEL; g++) begin : g_sel
    cs_match u_match (
      .baseReg (baseReg_ff[g]),
      .optReg  (optReg_ff[g]),
      .port16  (pinFunc_ff[2*g]),
      .acc     (busAcc),
      .hit     (genHit[g])
    );
  end

  cs_match u_boot (
    .baseReg (bootBase_ff),
    .optReg  (bootOpt_ff),
    .port16  (bootPinFunc_ff[0]),
    .acc     (busAcc),
    .hit     (bootHit)
  );

  // Outputs are registered; this adds one cycle after the strobe, the
  // price of glitch-free selects. Synchronous mode is not modelled.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      selectOut_n  <= '1;
      bootSelect_n <= 1'b1;
    end else begin
      for (int i = 0; i < NUM_SEL; i++) begin
        selectOut_n[i] <= ~(genHit[i] & pinFunc_ff[2*i+1]);
      end
      bootSelect_n <= ~(bootHit & bootPinFunc_ff[1]);
    end
  end

  assign pinFunc        = pinFunc_ff;
  assign bootPinFunc    = bootPinFunc_ff;
  assign bootOptView    = bootOpt_ff;
  assign bootBaseView   = bootBase_ff;
  // Reset fetch address for the core's vector fetch.
  assign firstFetchAddr = VEC_ADDR;

endmodule

// [rtl/cs_match.sv]
// Address and attribute compare for one chip select.
// Assumes registers and the bus access are on the system clock.
`timescale 1ns/1ps
module cs_match
  import cs_reset_pkg::*;
(
  input  wire base_reg_t   baseReg,
  input  wire option_reg_t optReg,
  input  wire logic        port16,
  input  wire bus_access_t acc,
  output logic             hit
);

  logic [12:0] mask;
  logic        spaceOk;
  logic        rwOk;
  logic        laneOk;
  logic        strobeOk;
  logic        lvlOk;

  // Block size widens the ignored low address bits by one per step.
  always_comb begin
    mask = 13'h1fff << baseReg.blkSize;
  end

  // Space compare; user and supervisor from function code bit 2.
  always_comb begin
    case (optReg.space)
      SPC_CPU:  spaceOk = (acc.funcCode == 3'h7);
      SPC_USER: spaceOk = ~acc.funcCode[2] & (acc.funcCode != 3'h0);
      SPC_SUP:  spaceOk = acc.funcCode[2] & (acc.funcCode != 3'h7);
      default:  spaceOk = (acc.funcCode != 3'h7) & (acc.funcCode != 3'h0);
    endcase
  end

  // Interrupt level only checked in CPU space; zero matches any.
  assign lvlOk = (optReg.space != SPC_CPU) ||
                 (optReg.irqLevelMatch == 3'h0) ||
                 (optReg.irqLevelMatch == acc.addr[3:1]);
  assign rwOk  = acc.read ? optReg.readWrite[0] : optReg.readWrite[1];
  // An 8-bit port takes any nonzero lane field; 16-bit checks lanes.
  assign laneOk = port16 ? |(optReg.byteLane & acc.lanes)
                         : (optReg.byteLane != BYTE_OFF);
  // Asynchronous assertion follows the chosen strobe.
  assign strobeOk = optReg.strobeDs ? acc.dataStrobe : acc.addrStrobe;

  assign hit = ((acc.addr[23:11] & mask) == (baseReg.baseAddr & mask)) &&
               spaceOk && lvlOk && rwOk && laneOk && strobeOk;

endmodule

// [test/chip_select_reset_config_chk.sv]
// Checker: reset values, strap capture and boot decode at the top ports.
// Assumes straps stay steady until the pin fields freeze.
`timescale 1ns/1ps
module chip_select_reset_config_chk
  import cs_reset_pkg::*;
#(
  parameter int unsigned NUM_SEL = NUM_CS
)
(
  input wire logic                 core_clk,
  input wire logic                 rstn,
  input wire logic [7:0]           dataStrap,
  input wire logic                 cfgWrite,
  input wire logic [3:0]           cfgIndex,
  input wire bus_access_t          busAcc,
  input wire logic [NUM_SEL-1:0]   selectOut_n,
  input wire logic                 bootSelect_n,
  input wire logic [2*NUM_SEL-1:0] pinFunc,
  input wire logic [1:0]           bootPinFunc,
  input wire option_reg_t          bootOptView,
  input wire base_reg_t            bootBaseView,
  input wire logic [23:0]          firstFetchAddr
);
  logic [2:0]           edgeCnt_ff;
  logic                 genWr_ff;
  logic                 bootWr_ff;
  logic [2*NUM_SEL-1:0] expPin;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // Edges since release; saturates so the freeze point stays visible.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      edgeCnt_ff <= 3'h0;
    end else if (edgeCnt_ff != 3'h7) begin
      edgeCnt_ff <= edgeCnt_ff + 3'h1;
    end
  end

  // Sticky write marks, since any write may legally enable a select.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      genWr_ff  <= 1'b0;
      bootWr_ff <= 1'b0;
    end else if (cfgWrite) begin
      genWr_ff  <= genWr_ff | (cfgIndex < 4'(NUM_SEL));
      bootWr_ff <= bootWr_ff | (cfgIndex == 4'(NUM_SEL));
    end
  end

  // Pin fields expected from the levels now on the data lines.
  always_comb begin
    for (int n = 0; n < NUM_SEL; n++) begin
      expPin[2*n]   = 1'b1;
      expPin[2*n+1] = dataStrap[1+n%7];
    end
  end

  ////////////////////////////////////////////////////////////////////
  sequence bootFetch;
    !bootWr_ff && busAcc.addrStrobe && busAcc.read &&
    busAcc.addr == VEC_ADDR && busAcc.funcCode == 3'h6;
  endsequence
  sequence strobesIdle;
    !busAcc.addrStrobe && !busAcc.dataStrobe;
  endsequence

  a_boot_opt_rst: assert property (
    $rose(rstn) |-> bootOptView == BOOT_OPT_RST)
    else $error("boot option not at reset value");
  a_boot_base_rst: assert property (
    $rose(rstn) |-> bootBaseView == BOOT_BASE_RST)
    else $error("boot base not at reset value");
  a_pin_low_ones: assert property (
    $rose(rstn) |-> bootPinFunc[1] && &(pinFunc | {NUM_SEL{2'h2}}))
    else $error("pin field reset bits wrong");
  a_strap_capture: assert property (
    edgeCnt_ff == 3'h5 |-> pinFunc == expPin &&
      bootPinFunc[0] == dataStrap[0])
    else $error("strap levels not captured");
  a_strap_hold: assert property (
    edgeCnt_ff > 3'h4 && !cfgWrite |=> $stable(pinFunc) &&
      $stable(bootPinFunc))
    else $error("pin fields moved without a write");
  a_gen_sel_off: assert property (
    !genWr_ff |-> &selectOut_n)
    else $error("general select before programming");
  a_boot_hit: assert property (
    bootFetch |=> !bootSelect_n)
    else $error("boot select missed first fetch");
  a_idle_release: assert property (
    strobesIdle |=> bootSelect_n && &selectOut_n)
    else $error("select asserted without strobe");
  a_fetch_addr: assert property (
    firstFetchAddr == VEC_ADDR)
    else $error("first fetch address not zero");
endmodule

bind chip_select_reset_config chip_select_reset_config_chk #(
  .NUM_SEL(NUM_SEL)
) i_chk (
  .core_clk, .rstn, .dataStrap, .cfgWrite, .cfgIndex, .busAcc,
  .selectOut_n, .bootSelect_n, .pinFunc, .bootPinFunc, .bootOptView,
  .bootBaseView, .firstFetchAddr
);

// [test/chip_select_reset_config_tb_top.sv]
// Testbench: strapped resets, reset values, boot fetch, lane decode.
// Assumes the package and the strap model are compiled first.
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin compares++; if ((sn) !== (ex)) begin \
  miscompares++; $display("BAD %s exp %h got %h", nm, ex, sn); end end
module chip_select_reset_config_tb_top
  import cs_reset_pkg::*;
;
  logic                core_clk;
  logic                rstn;
  logic                driveEn;
  logic [7:0]          driveVal;
  logic [7:0]          dataStrap;
  logic                cfgWrite;
  logic [3:0]          cfgIndex;
  logic                cfgIsBase;
  base_reg_t           cfgBase;
  option_reg_t         cfgOpt;
  logic [1:0]          cfgPinFunc;
  bus_access_t         busAcc;
  logic [NUM_CS-1:0]   selectOut_n;
  logic                bootSelect_n;
  logic [2*NUM_CS-1:0] pinFunc;
  logic [1:0]          bootPinFunc;
  option_reg_t         bootOptView;
  base_reg_t           bootBaseView;
  logic [23:0]         firstFetchAddr;
  logic [NUM_CS-1:0]   expSel;
  int                  compares;
  int                  miscompares;

  strap_drive i_strap (.driveEn, .driveVal, .dataStrap);
  chip_select_reset_config i_dut (
    .core_clk, .rstn, .dataStrap, .cfgWrite, .cfgIndex, .cfgIsBase,
    .cfgBase, .cfgOpt, .cfgPinFunc, .busAcc, .selectOut_n, .bootSelect_n,
    .pinFunc, .bootPinFunc, .bootOptView, .bootBaseView, .firstFetchAddr
  );

  // Free-running system clock, 20 ns period.
  always #10 core_clk = ~core_clk;

  // Pin fields the straps should produce; select n reads line 1+n%7.
  function automatic logic [2*NUM_CS-1:0] exp_pin(input logic [7:0] s);
    logic [2*NUM_CS-1:0] r;
    for (int n = 0; n < NUM_CS; n++) begin
      r[2*n]   = 1'b1;
      r[2*n+1] = s[1+n%7];
    end
    return r;
  endfunction

  // Reset for 4 cycles; straps are kept well past the freeze point.
  task automatic do_reset(input logic en, input logic [7:0] val);
    @(negedge core_clk);
    rstn     = 1'b0;
    driveEn  = en;
    driveVal = val;
    repeat (4) @(negedge core_clk);
    rstn = 1'b1;
    repeat (6) @(negedge core_clk);
  endtask

  // One write of select idx at 8 Mbyte; an option write sets its pins.
  task automatic cfg_write(input logic [3:0] idx, input logic isBase,
                           input logic [1:0] lane, input logic [1:0] pf);
    @(negedge core_clk);
    cfgWrite   = 1'b1;
    cfgIndex   = idx;
    cfgIsBase  = isBase;
    cfgBase    = '{13'h1000, BLK_2K};
    cfgOpt     = '{1'b0, lane, RW_BOTH, 1'b0, WAIT_0, SPC_SU, 3'h0, 1'b0};
    cfgPinFunc = pf;
    @(negedge core_clk);
    cfgWrite = 1'b0;
  endtask

  // Program-space read with address strobe, then strobe released.
  task automatic access(input logic [23:0] addr, input logic [1:0] lanes,
                        input logic eBoot, input logic [NUM_CS-1:0] eSel);
    busAcc = '{addr, 3'h6, 1'b1, lanes, 1'b1, 1'b0};
    @(negedge core_clk);
    `CHK("bootSelect_n", eBoot, bootSelect_n)
    `CHK("selectOut_n", eSel, selectOut_n)
    busAcc.addrStrobe = 1'b0;
    @(negedge core_clk);
    `CHK("idle", {(NUM_CS+1){1'b1}}, {bootSelect_n, selectOut_n})
  endtask

  task automatic give_verdict();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  // Watchdog: the sequence needs well under 200 cycles.
  initial begin
    repeat (1000) @(posedge core_clk);
    miscompares++;
    give_verdict();
  end

  // Main sequence: strapped reset, boot fetch, hold, decode, pulled reset.
  initial begin
    core_clk = 1'b0;
    rstn = 1'b0;
    driveEn = 1'b1;
    driveVal = 8'hA4;
    cfgWrite = 1'b0;
    cfgIndex = 4'h0;
    cfgIsBase = 1'b0;
    cfgBase = '0;
    cfgOpt = '0;
    cfgPinFunc = 2'h0;
    busAcc = '0;
    compares = 0;
    miscompares = 0;
    do_reset(1'b1, 8'hA4);
    `CHK("bootOptView", BOOT_OPT_RST, bootOptView)
    `CHK("bootBaseView", BOOT_BASE_RST, bootBaseView)
    `CHK("bootPinFunc", 2'h2, bootPinFunc)
    `CHK("pinFunc", exp_pin(8'hA4), pinFunc)
    `CHK("firstFetchAddr", VEC_ADDR, firstFetchAddr)
    access(VEC_ADDR, BYTE_BOTH, 1'b0, {NUM_CS{1'b1}});
    driveVal = 8'h5B;
    repeat (2) @(negedge core_clk);
    `CHK("held pins", exp_pin(8'hA4), pinFunc)
    cfg_write(4'h3, 1'b1, BYTE_OFF, 2'h2);
    // Select 3 as an 8-bit port, then as a 16-bit port, every lane field.
    for (int k = 0; k < 8; k++) begin
      cfg_write(4'h3, 1'b0, k[1:0], {1'b1, k[2]});
      expSel = {NUM_CS{1'b1}};
      expSel[3] = ~(k[2] ? k[1] : (k[1:0] != 2'h0));
      access(24'h80_0000, BYTE_UP, 1'b1, expSel);
    end
    // Select 5 keeps its reset base: zero, one 2 Kbyte block.
    cfg_write(4'h5, 1'b0, BYTE_BOTH, 2'h2);
    access(VEC_ADDR, BYTE_BOTH, 1'b0, {NUM_CS{1'b1}} ^ 11'h020);
    access(24'h00_0800, BYTE_BOTH, 1'b0, {NUM_CS{1'b1}});
    do_reset(1'b0, 8'h00);
    `CHK("pulled pins", {(2*NUM_CS){1'b1}}, pinFunc)
    `CHK("pulled boot", 2'h3, bootPinFunc)
    `CHK("selects off", {NUM_CS{1'b1}}, selectOut_n)
    give_verdict();
  end
endmodule

// [test/strap_drive.sv]
// Far-side model: board logic that straps the data lines during reset.
// Assumes the device holds each data line weakly high.
`timescale 1ns/1ps
module strap_drive (
  input  wire logic       driveEn,
  input  wire logic [7:0] driveVal,
  output logic [7:0]      dataStrap
);
  // A released line rises to the pull-up level, never a stale value.
  assign dataStrap = driveEn ? driveVal : 8'hFF;
endmodule
